/* logic/aps_pkg.sv */
// package: constants and types for the amplifier protection sequencer
package aps_pkg;
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned RESTART_MS      = 100;
	localparam int unsigned RESTART_CYCLES  = CLK_HZ / 1000 * RESTART_MS;
	localparam int unsigned TIMER_W         = 23;
	localparam logic [22:0] TIMER_ZERO      = 23'h000000;
	localparam logic [22:0] TIMER_ONE       = 23'h000001;
	localparam int unsigned NUM_CH          = 2;
	localparam logic        FAULT_FLAG_PIN_ACTIVE     = 1'b0;

	typedef enum logic [2:0] {
		APS_SLEEP,
		APS_CHARGE,
		APS_WINDOW,
		APS_MUTE,
		APS_OPERATE,
		APS_FAULT_WAIT,
		APS_FAULT_HOLD
	} aps_state_e;
endpackage : aps_pkg

/* logic/aps_restart_timer.sv */
// module: reloadable countdown for the restart delay
`timescale 1ns/1ps
module aps_restart_timer #(
	parameter int unsigned CYCLES = aps_pkg::RESTART_CYCLES
) (
	// clock and reset
	input  wire logic                        mclk_i,
	input  wire logic                        srst_i,
	// control
	input  wire logic                        load_i,
	// status
	output logic                             done_o
);
	import aps_pkg::*;

	// the counter cannot hold a longer delay, and one cycle is no delay
	if (CYCLES < 2 || CYCLES >= (1 << TIMER_W))
	begin : g_bad_cycles
		$error("aps_restart_timer: CYCLES out of range");
	end

	localparam logic [TIMER_W-1:0] LOAD_VAL = TIMER_W'(CYCLES - 1);

	logic [TIMER_W-1:0] count_reg;
	logic               done_reg;
	wire                at_zero = (count_reg == TIMER_ZERO);

	// reload on any new fault so the delay counts from the last event
	always_ff @(posedge mclk_i)
	begin
		if (srst_i || load_i)
			count_reg <= LOAD_VAL;
		else if (!at_zero)
			count_reg <= count_reg - TIMER_ONE;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i || load_i)
			done_reg <= 1'b0;
		else
			done_reg <= (count_reg == TIMER_ONE) || at_zero;
	end

	assign done_o = done_reg;

	AST_RELOAD_CLEARS_DONE: assert property (@(posedge mclk_i) disable iff (srst_i)
		load_i |=> !done_o) else $error("done seen right after reload");
endmodule : aps_restart_timer

/* logic/aps_seq.sv */
// module: fault protection and restart sequencer, top level
`timescale 1ns/1ps
// Function
// - over-temperature disables power stage immediately
// - overcurrent clamps to limit, keeps switching
// - load short: off, restart 100 ms after clear
// - rail short: off, wait 100ms, window check
// - impedance drop only limits, never switches off
// - window check before mute; hold while shorted
// - undervoltage: silent shutdown, restart after 100ms
// - overvoltage: stages off, restart after 100ms
// - rail imbalance outside window raises fault
// - symmetric imbalance releases within 6 percent
// - ocp/window resume on clear, others 100 ms after clear
// - fault_flag_pin pin low from a shutdown fault until restart delay ends, not for ocp or window hold
// - external low on fault_flag_pin forces fault
// - half-supply buffers only asymmetric, when awake
// - switching waits for capacitors charged
// - wake/unmute pins select sleep, mute, operate
// - mute: idle switching, input stages off
module aps_seq #(
	parameter int unsigned RESTART_CYCLES = aps_pkg::RESTART_CYCLES
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic srst_i,
	// host mode pins
	input  wire logic wake_select_i,
	input  wire logic audio_unmute_select_i,
	// open-drain diagnostic pin
	input  wire logic fault_flag_pin_i,
	output logic      fault_flag_pin_o,
	output logic      fault_flag_pin_oe_o,
	// analog fault indications
	input  wire logic over_temp_i,
	input  wire logic over_current_i,
	input  wire logic load_short_i,
	input  wire logic rail_short_i,
	input  wire logic low_supply_guard_i,
	input  wire logic high_supply_guard_i,
	input  wire logic imbalance_outside_i,
	input  wire logic imbalance_within_6pct_i,
	input  wire logic heat_gain_reduction_i,
	input  wire logic outputs_open_i,
	input  wire logic caps_charged_i,
	// configuration
	input  wire logic symmetric_supply_i,
	// power stage control
	output logic      power_stage_en_o,
	output logic      current_limit_o,
	output logic      input_stage_en_o,
	output logic      idle_switch_o,
	output logic      window_check_o,
	output logic      half_supply_out_ch1_o,
	output logic      half_supply_out_ch2_o,
	output logic      midrail_ref_out_o,
	output logic      imbalance_fault_o
);
	import aps_pkg::*;

	aps_state_e state_reg;
	aps_state_e state_next;
	logic       imb_reg;
	logic       imb_next;
	logic       pstage_reg;
	logic       limit_reg;
	logic       instage_reg;
	logic       idle_reg;
	logic       win_reg;
	logic       hsup_reg;
	logic       ref_reg;
	logic       fault_flag_pin_low_reg;
	logic       timer_done;

	// ----------------------------------------------------------------
	// fault decode
	// ----------------------------------------------------------------
	// imbalance sets outside the window; symmetric supply needs 6 %
	assign imb_next = imbalance_outside_i ? 1'b1 :
		(!imb_reg) ? 1'b0 :
		(symmetric_supply_i ? imbalance_within_6pct_i ? 1'b0 : 1'b1
		: 1'b0);

	// over_current alone is an impedance drop: limit only
	// imbalance acts in the cycle it is seen, like the other faults
	wire periodic_fault = over_temp_i | low_supply_guard_i |
		high_supply_guard_i | imb_next;
	wire short_fault    = load_short_i | rail_short_i;
	wire ext_fault      = (fault_flag_pin_i == FAULT_FLAG_PIN_ACTIVE) &
		!fault_flag_pin_low_reg;
	wire any_fault      = periodic_fault | short_fault | ext_fault;
	// held in reload while a fault stands: the delay runs from the clear
	wire timer_load     = any_fault | (state_reg == APS_SLEEP);
	wire awake          = wake_select_i;

	// ----------------------------------------------------------------
	// restart delay
	// ----------------------------------------------------------------
	aps_restart_timer #(
		.CYCLES (RESTART_CYCLES)
	) u_timer (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.load_i (timer_load),
		.done_o (timer_done)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			APS_SLEEP:
				if (awake)
					state_next = APS_CHARGE;
			APS_CHARGE:
				if (any_fault)
					state_next = APS_FAULT_HOLD;
				else if (caps_charged_i)
					state_next = APS_WINDOW;
			APS_WINDOW:
				if (any_fault)
					state_next = APS_FAULT_HOLD;
				else if (outputs_open_i)
					state_next = APS_MUTE;
			APS_MUTE, APS_OPERATE:
				if (any_fault)
					state_next = APS_FAULT_HOLD;
				else
					state_next = audio_unmute_select_i ?
						APS_OPERATE : APS_MUTE;
			APS_FAULT_HOLD:
				if (!any_fault)
					state_next = APS_FAULT_WAIT;
			APS_FAULT_WAIT:
				if (any_fault)
					state_next = APS_FAULT_HOLD;
				else if (timer_done)
					state_next = APS_WINDOW;
		endcase
		if (!awake)
			state_next = APS_SLEEP;
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			state_reg       <= APS_SLEEP;
			imb_reg         <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			imb_reg         <= awake & imb_next;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	wire run_next  = (state_next == APS_MUTE) | (state_next == APS_OPERATE);
	// over-temperature cuts in the same cycle it is seen
	wire pst_next  = run_next & !over_temp_i & !any_fault;
	wire lim_next  = run_next & over_current_i & !short_fault;
	wire ins_next  = (state_next == APS_OPERATE) & pst_next;
	wire idle_next = (state_next == APS_MUTE) & pst_next;
	wire win_next  = (state_next == APS_WINDOW);
	wire hs_next   = awake & !symmetric_supply_i;
	// the pin we pull low ourselves is not read back as a fault
	wire fault_flag_pin_next = awake & (any_fault |
		(state_next == APS_FAULT_HOLD) |
		(state_next == APS_FAULT_WAIT));
	// external pull-down alone: we do not hold the pin ourselves
	wire ext_fault_only = ext_fault & !periodic_fault & !short_fault;

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			pstage_reg   <= 1'b0;
			limit_reg    <= 1'b0;
			instage_reg  <= 1'b0;
			idle_reg     <= 1'b0;
			win_reg      <= 1'b0;
			hsup_reg     <= 1'b0;
			ref_reg      <= 1'b0;
			fault_flag_pin_low_reg <= 1'b0;
		end
		else
		begin
			pstage_reg   <= pst_next;
			limit_reg    <= lim_next;
			instage_reg  <= ins_next;
			idle_reg     <= idle_next;
			win_reg      <= win_next;
			hsup_reg     <= hs_next;
			ref_reg      <= awake;
			fault_flag_pin_low_reg <= fault_flag_pin_next & !ext_fault_only;
		end
	end

	assign power_stage_en_o      = pstage_reg;
	assign current_limit_o       = limit_reg;
	assign input_stage_en_o      = instage_reg;
	assign idle_switch_o         = idle_reg;
	assign window_check_o        = win_reg;
	assign half_supply_out_ch1_o = hsup_reg;
	assign half_supply_out_ch2_o = hsup_reg;
	assign midrail_ref_out_o     = ref_reg;
	assign imbalance_fault_o     = imb_reg;
	assign fault_flag_pin_o      = FAULT_FLAG_PIN_ACTIVE;
	assign fault_flag_pin_oe_o   = fault_flag_pin_low_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_OTP_CUTS: assert property (@(posedge mclk_i) disable iff (srst_i)
		over_temp_i |=> !power_stage_en_o) else $error("otp no cut");
	AST_LIMIT_KEEPS_ON: assert property (@(posedge mclk_i)
		disable iff (srst_i)
		current_limit_o |-> power_stage_en_o) else $error("limit off");
	AST_SHORT_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
		(load_short_i | rail_short_i) |=> !power_stage_en_o)
		else $error("short not off");
	AST_UV_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
		low_supply_guard_i |=> !power_stage_en_o) else $error("uv");
	AST_OV_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
		high_supply_guard_i |=> !power_stage_en_o) else $error("ov");
	AST_IMB_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
		(wake_select_i & imbalance_outside_i) |=> imbalance_fault_o)
		else $error("imbalance not flagged");
	AST_FAULT_FLAG_PIN_LOW: assert property (@(posedge mclk_i) disable iff (srst_i)
		(wake_select_i & over_temp_i) |=> fault_flag_pin_oe_o)
		else $error("fault_flag_pin not pulled");
	AST_SLEEP: assert property (@(posedge mclk_i) disable iff (srst_i)
		!wake_select_i |=> (!power_stage_en_o && !fault_flag_pin_oe_o))
		else $error("not asleep");
	AST_HALF_SUPPLY: assert property (@(posedge mclk_i) disable iff (srst_i)
		symmetric_supply_i |=> !half_supply_out_ch1_o)
		else $error("half supply on");
	AST_GAIN_NO_FAULT_FLAG_PIN: assert property (@(posedge mclk_i) disable iff (srst_i)
		(heat_gain_reduction_i & !fault_flag_pin_next) |=> !fault_flag_pin_oe_o)
		else $error("fault_flag_pin pulled on gain reduction");

	COV_OPERATE: cover property (@(posedge mclk_i) state_reg == APS_OPERATE);
	COV_RETRY: cover property (@(posedge mclk_i)
		state_reg == APS_FAULT_WAIT ##1 state_reg == APS_WINDOW);
	COV_LIMIT: cover property (@(posedge mclk_i) current_limit_o);
endmodule : aps_seq

/* test/aps_host_model.sv */
// model: host controller on the mode pins and the diagnostic line
`timescale 1ns/1ps
module aps_host_model (
	// requests from the bench
	input  wire logic wake_req_i,
	input  wire logic unmute_req_i,
	input  wire logic ext_fault_req_i,
	// diagnostic pin, device side
	input  wire logic dut_data_i,
	input  wire logic dut_oe_i,
	// mode pins and resolved pin level
	output logic      wake_select_o,
	output logic      audio_unmute_select_o,
	output logic      fault_flag_pin_o
);
	// unmute is only raised once awake, so sleep never sees it alone
	assign wake_select_o         = wake_req_i;
	assign audio_unmute_select_o = wake_req_i & unmute_req_i;
	// open drain: any party pulls low, weak pull-up otherwise
	assign fault_flag_pin_o = ext_fault_req_i ? 1'h0 :
		(dut_oe_i ? dut_data_i : 1'h1);
endmodule : aps_host_model

/* test/tb_aps_seq.sv */
// testbench: self-checking bench for the protection sequencer
`timescale 1ns/1ps
module tb_aps_seq;
	import aps_pkg::*;
	localparam int unsigned RC = 50;
	logic       mclk_i = 1'h0;
	logic       srst_i = 1'h1;
	logic       wake_req = 1'h0;
	logic       unmute_req = 1'h0;
	logic       ext_req = 1'h0;
	logic       ocur = 1'h0;
	logic       heat = 1'h0;
	logic       open = 1'h0;
	logic       caps = 1'h0;
	logic       sym = 1'h0;
	logic       in6 = 1'h1;
	logic [5:0] flt = 6'h00;
	logic       wake, unmute, pin, pin_o, pin_oe;
	logic       pwr, lim, inen, idle, win, hs1, hs2, imb, mref;
	int         n_errors = 0;
	int         n_compared = 0;
	int         cyc = 0;

	aps_host_model i_host (.wake_req_i(wake_req), .unmute_req_i(unmute_req),
		.ext_fault_req_i(ext_req), .dut_data_i(pin_o), .dut_oe_i(pin_oe),
		.wake_select_o(wake), .audio_unmute_select_o(unmute),
		.fault_flag_pin_o(pin));
	aps_seq #(.RESTART_CYCLES(RC)) i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
		.wake_select_i(wake), .audio_unmute_select_i(unmute),
		.fault_flag_pin_i(pin), .fault_flag_pin_o(pin_o),
		.fault_flag_pin_oe_o(pin_oe), .over_temp_i(flt[0]),
		.over_current_i(ocur), .load_short_i(flt[1]), .rail_short_i(flt[2]),
		.low_supply_guard_i(flt[3]), .high_supply_guard_i(flt[4]),
		.imbalance_outside_i(flt[5]), .imbalance_within_6pct_i(in6),
		.heat_gain_reduction_i(heat), .outputs_open_i(open),
		.caps_charged_i(caps), .symmetric_supply_i(sym),
		.power_stage_en_o(pwr), .current_limit_o(lim),
		.input_stage_en_o(inen), .idle_switch_o(idle), .window_check_o(win),
		.half_supply_out_ch1_o(hs1), .half_supply_out_ch2_o(hs2),
		.midrail_ref_out_o(mref), .imbalance_fault_o(imb));

	initial
	begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	task automatic finish_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(input logic got, input logic exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic cyc_n(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : cyc_n

	// bounded wait covers restart delay, window check and mute entry
	task automatic wait_pwr(input logic v);
		int i;
		for (i = 0; i < 400 && pwr !== v; i++)
			@(negedge mclk_i);
		chk(pwr, v, "power stage enable");
	endtask : wait_pwr

	task automatic t_startup;
		wake_req = 1'h1;
		cyc_n(10);
		chk(pwr, 1'h0, "switching before caps charged");
		chk(hs1, 1'h1, "half supply ch1 off");
		chk(hs2, 1'h1, "half supply ch2 off");
		chk(mref, 1'h1, "midrail reference off");
		caps = 1'h1;
		cyc_n(10);
		chk(win, 1'h1, "window check idle");
		chk(pwr, 1'h0, "switching with shorted outputs");
		open = 1'h1;
		wait_pwr(1'h1);
		cyc_n(1);
		chk(idle, 1'h1, "mute idle switching");
		chk(inen, 1'h0, "inputs on in mute");
		unmute_req = 1'h1;
		cyc_n(2);
		chk(inen, 1'h1, "inputs off in operate");
		chk(pin_oe, 1'h0, "fault_flag_pin pulled when healthy");
	endtask : t_startup

	task automatic t_ocur;
		ocur = 1'h1;
		cyc_n(3);
		chk(lim, 1'h1, "no current limit");
		chk(pwr, 1'h1, "stage off on overcurrent");
		ocur = 1'h0;
		heat = 1'h1;
		cyc_n(3);
		chk(pin_oe, 1'h0, "fault_flag_pin pulled on gain reduction");
		heat = 1'h0;
	endtask : t_ocur

	task automatic t_ext;
		ext_req = 1'h1;
		cyc_n(2);
		chk(pwr, 1'h0, "external low ignored");
		chk(pin_oe, 1'h0, "own pull on external fault");
		ext_req = 1'h0;
		wait_pwr(1'h1);
	endtask : t_ext

	// one pass per shutdown fault, each with its delayed restart
	task automatic t_faults;
		int k;
		for (k = 0; k < 6; k++)
		begin
			flt[k] = 1'h1;
			cyc_n(1);
			chk(pwr, 1'h0, "stage on during fault");
			cyc_n(1);
			chk(pin_oe, 1'h1, "fault_flag_pin released during fault");
			if (k == 5)
				chk(imb, 1'h1, "imbalance flag low");
			flt[k] = 1'h0;
			cyc_n(RC - 10);
			chk(pwr, 1'h0, "restart too early");
			wait_pwr(1'h1);
		end
	endtask : t_faults

	task automatic t_sym;
		wake_req = 1'h0;
		cyc_n(2);
		chk(pwr, 1'h0, "stage on in sleep");
		chk(hs1, 1'h0, "half supply on in sleep");
		chk(mref, 1'h0, "midrail reference on in sleep");
		sym = 1'h1;
		wake_req = 1'h1;
		cyc_n(10);
		chk(hs1, 1'h0, "half supply ch1 symmetric");
		chk(hs2, 1'h0, "half supply ch2 symmetric");
		wait_pwr(1'h1);
	endtask : t_sym

	// symmetric supply: imbalance held until back within 6 percent
	task automatic t_imb_sym;
		in6 = 1'h0;
		flt[5] = 1'h1;
		cyc_n(2);
		chk(imb, 1'h1, "symmetric imbalance not flagged");
		chk(pwr, 1'h0, "stage on during imbalance");
		chk(pin_oe, 1'h1, "fault_flag_pin released on imbalance");
		flt[5] = 1'h0;
		cyc_n(3);
		chk(imb, 1'h1, "imbalance released early");
		chk(pwr, 1'h0, "restart before release");
		in6 = 1'h1;
		cyc_n(2);
		chk(imb, 1'h0, "imbalance not released");
		wait_pwr(1'h1);
	endtask : t_imb_sym

	// mid-run reset: outputs low, then a fresh start-up
	task automatic t_reset;
		srst_i = 1'h1;
		cyc_n(2);
		chk(pwr, 1'h0, "stage on in reset");
		chk(pin_oe, 1'h0, "fault_flag_pin pulled in reset");
		chk(mref, 1'h0, "midrail reference on in reset");
		srst_i = 1'h0;
		wait_pwr(1'h1);
	endtask : t_reset

	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			finish_test;
		end
	end

	initial
	begin
		cyc_n(4);
		srst_i = 1'h0;
		t_startup;
		t_ocur;
		t_ext;
		t_faults;
		t_sym;
		t_imb_sym;
		t_reset;
		finish_test;
	end
endmodule : tb_aps_seq
